// ### msirq_defines.svh
// Register map, field positions and fixed codes of the interrupt source block
`ifndef MSIRQ_DEFINES_SVH
`define MSIRQ_DEFINES_SVH

// =============================================================
// Register byte addresses
`define MSIRQ_ADDR_OUT_FIRST    8'h01
`define MSIRQ_ADDR_BUF_STATUS   8'h00
`define MSIRQ_ADDR_SYSTEM_MODE  8'h0B
`define MSIRQ_ADDR_SUMMARY      8'h0C
`define MSIRQ_ADDR_IDENTITY     8'h0D
`define MSIRQ_ADDR_TRANS_SRC    8'h1E
`define MSIRQ_ADDR_ORIENT_STAT  8'h10
`define MSIRQ_ADDR_FFMT_SRC     8'h16
`define MSIRQ_ADDR_TAP_SRC      8'h22
`define MSIRQ_ADDR_MAG_EVENT    8'h5E
`define MSIRQ_ADDR_MAG_FIRST    8'h33
`define MSIRQ_ADDR_MAG_LAST     8'h38
`define MSIRQ_ADDR_ACC_LAST     8'h06
`define MSIRQ_ADDR_HYB_LAST     8'h0C

// =============================================================
// Summary register bit positions
`define MSIRQ_BIT_SLEEPWAKE     7
`define MSIRQ_BIT_BUFFER        6
`define MSIRQ_BIT_TRANSIENT     5
`define MSIRQ_BIT_ORIENT        4
`define MSIRQ_BIT_TAP           3
`define MSIRQ_BIT_FFMT          2
`define MSIRQ_BIT_MAGNITUDE     1
`define MSIRQ_BIT_DRDY          0

// =============================================================
// Fixed values
`define MSIRQ_SUMMARY_RESET     8'h00
`define MSIRQ_IDENTITY_DEFAULT  8'h5A
`define MSIRQ_HYB_BURST_LEN     4'hC
`define MSIRQ_BYTE_ZERO         8'h00

`endif

// ### msirq_pkg.sv
// Types shared by the interrupt source block
package msirq_pkg;
    typedef enum logic [1:0] {
        MSIRQ_MODE_STANDBY = 2'b00,
        MSIRQ_MODE_WAKE    = 2'b01,
        MSIRQ_MODE_SLEEP   = 2'b10
    } msirq_sysmode_type;

    typedef enum logic [1:0] {
        MSIRQ_SENSE_ACCEL  = 2'b00,
        MSIRQ_SENSE_MAG    = 2'b01,
        MSIRQ_SENSE_HYBRID = 2'b11
    } msirq_sense_type;
endpackage

// ### msirq_sticky_flag.sv
// One sticky flag: set by an event, cleared by a read, set wins
module msirq_sticky_flag
    import msirq_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic setEvent,
    input  wire logic clearRead,
    output logic      flag
);
    // A set in the same cycle as the clear survives
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (clearRead) begin
            flag <= 1'b0;
        end
    end
endmodule

// ### msirq_source.sv
// Interrupt summary register, sleep/wake sequencing and identity register
// Notes on behaviour
// - Each summary bit shows one while its function has asserted an interrupt.
// - Magnetic interrupt flags live in their own register, not the summary.
// - Reading the summary register clears only the magnitude flag.
// - Each flag except magnitude clears when that function's source register is read.
// - Sleep/wake flag sets on any event causing a wake/sleep transition.
// - Wake goes to sleep at the low rate after inactivity exceeds the limit.
// - Sleep goes to wake at the higher rate on the chosen wake event.
// - Reading the system mode register clears the sleep/wake flag.
// - Buffer flag sets on overflow or count reaching the watermark; here only on a new sample while either is high.
// - Reading the buffer status register clears the buffer flag.
// - Transient flag sets while event-active is high and its interrupt enabled.
// - Reading the transient source register clears the transient flag.
// - Orientation flag sets on orientation change with its interrupt enabled.
// - Reading the orientation status register clears the orientation flag.
// - Tap flag sets on single or double pulse interrupt when enabled.
// - Reading the tap source register clears the tap flag.
// - Freefall/motion flag holds while active; cleared by freefall source read.
// - Magnitude flag sets on magnitude interrupt, clears on summary read.
// - Data ready means new accel, magnetic, or either data per sensing mode.
// - Data ready clears on accel read, or magnetic read in mag/hybrid.
// - Hybrid increment mode returns twelve data bytes from the first output byte.
// - Read-only 8-bit identity register holds a fixed device code.
`include "msirq_defines.svh"

module msirq_source
    import msirq_pkg::*;
#(
    parameter int         INACT_WIDTH = 8,
    parameter logic [7:0] IDENT_CODE  = `MSIRQ_IDENTITY_DEFAULT  // Arbitrary value
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register read port of the serial interface
    input  wire logic                   regRead,
    input  wire logic [7:0]             regAddr,
    output logic      [7:0]             regReadData,
    output logic                        regReadValid,
    // Burst address pointer service
    input  wire logic                   burstStart,
    input  wire logic                   burstNext,
    output logic      [7:0]             burstAddr,
    output logic                        burstActive,
    // Configuration from control registers
    input  wire logic                   active,
    input  wire logic                   autoSleepEnable,
    input  wire logic                   hybridAutoInc,
    input  wire msirq_sense_type        senseMode,
    input  wire logic [INACT_WIDTH-1:0] inactivityLimit,
    input  wire logic                   transientIntEnable,
    input  wire logic                   orientIntEnable,
    input  wire logic                   tapIntEnable,
    input  wire logic                   ffmtIntEnable,
    input  wire logic                   magnitudeIntEnable,
    input  wire logic                   wakeEventSelect,
    // Event levels and pulses from the detection functions
    input  wire logic                   outputRateTick,
    input  wire logic                   activityDetected,
    input  wire logic                   bufferOverflow,
    input  wire logic                   bufferWatermark,
    input  wire logic                   bufferSampleIn,
    input  wire logic                   event_active,
    input  wire logic                   orientChanged,
    input  wire logic                   tapEventActive,
    input  wire logic                   ffmtEventActive,
    input  wire logic                   magnitudeEvent,
    input  wire logic                   accelDataNew,
    input  wire logic                   magDataNew,
    input  wire logic [7:0]             magEventFlags,
    // Status outputs
    output msirq_sysmode_type           systemMode,
    output logic                        sleepRateSelect,
    output logic [7:0]                  interruptSummary
);

    // ==========================================================
    // Read strobes for each clearing register
    logic rdSummary;
    logic rdSysMode;
    logic rdBuffer;
    logic rdTrans;
    logic rdOrient;
    logic rdTap;
    logic rdFfmt;
    logic rdAccel;
    logic rdMag;

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        rdSummary = regRead && (regAddr == `MSIRQ_ADDR_SUMMARY);
        rdSysMode = regRead && (regAddr == `MSIRQ_ADDR_SYSTEM_MODE);
        rdBuffer  = regRead && (regAddr == `MSIRQ_ADDR_BUF_STATUS);
        rdTrans   = regRead && (regAddr == `MSIRQ_ADDR_TRANS_SRC);
        rdOrient  = regRead && (regAddr == `MSIRQ_ADDR_ORIENT_STAT);
        rdTap     = regRead && (regAddr == `MSIRQ_ADDR_TAP_SRC);
        rdFfmt    = regRead && (regAddr == `MSIRQ_ADDR_FFMT_SRC);
        rdAccel   = regRead && inRange(regAddr, `MSIRQ_ADDR_OUT_FIRST, `MSIRQ_ADDR_ACC_LAST);
        rdMag     = regRead && inRange(regAddr, `MSIRQ_ADDR_MAG_FIRST, `MSIRQ_ADDR_MAG_LAST);
    end

    // ==========================================================
    // Sleep/wake sequencing
    msirq_sysmode_type       next_systemMode;
    logic [INACT_WIDTH-1:0]  inactCount;
    logic                    sleepEvent;
    logic                    wakeEvent;
    logic                    wakeSource;

    // Chosen wake source: activity, or an enabled transient or freefall/motion event
    always_comb begin
        if (wakeEventSelect) begin
            wakeSource = (transientIntEnable && event_active) || (ffmtIntEnable && ffmtEventActive);
        end else begin
            wakeSource = activityDetected;
        end
    end

    assign sleepEvent = (systemMode == MSIRQ_MODE_WAKE) && autoSleepEnable && outputRateTick
                        && !activityDetected && (inactCount >= inactivityLimit);
    assign wakeEvent  = (systemMode == MSIRQ_MODE_SLEEP) && wakeSource;

    always_comb begin
        next_systemMode = systemMode;
        case (systemMode)
            MSIRQ_MODE_STANDBY: begin
                if (active) begin
                    next_systemMode = MSIRQ_MODE_WAKE;
                end
            end
            MSIRQ_MODE_WAKE: begin
                if (!active) begin
                    next_systemMode = MSIRQ_MODE_STANDBY;
                end else if (sleepEvent) begin
                    next_systemMode = MSIRQ_MODE_SLEEP;
                end
            end
            MSIRQ_MODE_SLEEP: begin
                if (!active) begin
                    next_systemMode = MSIRQ_MODE_STANDBY;
                end else if (wakeEvent) begin
                    next_systemMode = MSIRQ_MODE_WAKE;
                end
            end
            default: begin
                next_systemMode = MSIRQ_MODE_STANDBY;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            systemMode <= MSIRQ_MODE_STANDBY;
        end else begin
            systemMode <= next_systemMode;
        end
    end

    // Low rate only while asleep; wake restores the higher rate
    always_ff @(posedge clk) begin
        if (rst) begin
            sleepRateSelect <= 1'b0;
        end else begin
            sleepRateSelect <= (next_systemMode == MSIRQ_MODE_SLEEP);
        end
    end

    // Counts quiet output-rate periods; saturates so a long quiet spell cannot wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            inactCount <= '0;
        end else if (systemMode != MSIRQ_MODE_WAKE || activityDetected) begin
            inactCount <= '0;
        end else if (outputRateTick && inactCount != '1) begin
            inactCount <= inactCount + 1'b1;
        end
    end

    // ==========================================================
    // Sticky flags, set wins over the clearing read
    logic [7:0] flagSet;
    logic [7:0] flagClear;

    always_comb begin
        flagSet   = `MSIRQ_BYTE_ZERO;
        flagClear = `MSIRQ_BYTE_ZERO;
        flagSet[`MSIRQ_BIT_SLEEPWAKE]  = sleepEvent || wakeEvent;
        flagSet[`MSIRQ_BIT_BUFFER]     = bufferOverflow || bufferWatermark ? bufferSampleIn : 1'b0;
        flagSet[`MSIRQ_BIT_TRANSIENT]  = event_active && transientIntEnable;
        flagSet[`MSIRQ_BIT_ORIENT]     = orientChanged && orientIntEnable;
        flagSet[`MSIRQ_BIT_TAP]        = tapEventActive && tapIntEnable;
        flagSet[`MSIRQ_BIT_FFMT]       = ffmtEventActive && ffmtIntEnable;
        flagSet[`MSIRQ_BIT_MAGNITUDE]  = magnitudeEvent && magnitudeIntEnable;
        case (senseMode)
            MSIRQ_SENSE_ACCEL: begin
                flagSet[`MSIRQ_BIT_DRDY] = accelDataNew;
            end
            MSIRQ_SENSE_MAG: begin
                flagSet[`MSIRQ_BIT_DRDY] = magDataNew;
            end
            default: begin
                flagSet[`MSIRQ_BIT_DRDY] = accelDataNew || magDataNew;
            end
        endcase
        flagClear[`MSIRQ_BIT_SLEEPWAKE] = rdSysMode;
        flagClear[`MSIRQ_BIT_BUFFER]    = rdBuffer;
        flagClear[`MSIRQ_BIT_TRANSIENT] = rdTrans;
        flagClear[`MSIRQ_BIT_ORIENT]    = rdOrient;
        flagClear[`MSIRQ_BIT_TAP]       = rdTap;
        flagClear[`MSIRQ_BIT_FFMT]      = rdFfmt;
        flagClear[`MSIRQ_BIT_MAGNITUDE] = rdSummary;
        flagClear[`MSIRQ_BIT_DRDY]      = (senseMode == MSIRQ_SENSE_ACCEL) ? rdAccel : rdMag;
    end

    // Buffer flag only re-arms on a new sample, so a lingering overflow level
    // does not immediately re-set it after the status read.
    msirq_sticky_flag uFlagSleep (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_SLEEPWAKE]),
        .clearRead (flagClear[`MSIRQ_BIT_SLEEPWAKE]),
        .flag      (interruptSummary[`MSIRQ_BIT_SLEEPWAKE])
    );

    msirq_sticky_flag uFlagBuffer (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_BUFFER]),
        .clearRead (flagClear[`MSIRQ_BIT_BUFFER]),
        .flag      (interruptSummary[`MSIRQ_BIT_BUFFER])
    );

    msirq_sticky_flag uFlagTrans (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_TRANSIENT]),
        .clearRead (flagClear[`MSIRQ_BIT_TRANSIENT]),
        .flag      (interruptSummary[`MSIRQ_BIT_TRANSIENT])
    );

    msirq_sticky_flag uFlagOrient (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_ORIENT]),
        .clearRead (flagClear[`MSIRQ_BIT_ORIENT]),
        .flag      (interruptSummary[`MSIRQ_BIT_ORIENT])
    );

    msirq_sticky_flag uFlagTap (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_TAP]),
        .clearRead (flagClear[`MSIRQ_BIT_TAP]),
        .flag      (interruptSummary[`MSIRQ_BIT_TAP])
    );

    msirq_sticky_flag uFlagMotion (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_FFMT]),
        .clearRead (flagClear[`MSIRQ_BIT_FFMT]),
        .flag      (interruptSummary[`MSIRQ_BIT_FFMT])
    );

    msirq_sticky_flag uFlagMagn (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_MAGNITUDE]),
        .clearRead (flagClear[`MSIRQ_BIT_MAGNITUDE]),
        .flag      (interruptSummary[`MSIRQ_BIT_MAGNITUDE])
    );

    msirq_sticky_flag uFlagReady (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (flagSet[`MSIRQ_BIT_DRDY]),
        .clearRead (flagClear[`MSIRQ_BIT_DRDY]),
        .flag      (interruptSummary[`MSIRQ_BIT_DRDY])
    );

    // ==========================================================
    // Hybrid burst pointer: twelve bytes from the first output byte
    logic [3:0] burstLeft;

    always_ff @(posedge clk) begin
        if (rst) begin
            burstAddr   <= `MSIRQ_ADDR_OUT_FIRST;
            burstLeft   <= 4'h0;
            burstActive <= 1'b0;
        end else if (burstStart && hybridAutoInc && senseMode == MSIRQ_SENSE_HYBRID) begin
            burstAddr   <= `MSIRQ_ADDR_OUT_FIRST;
            burstLeft   <= `MSIRQ_HYB_BURST_LEN - 4'h1;
            burstActive <= 1'b1;
        end else if (burstActive && burstNext) begin
            if (burstLeft == 4'h0) begin
                burstActive <= 1'b0;
            end else begin
                burstAddr <= burstAddr + 8'h01;
                burstLeft <= burstLeft - 4'h1;
            end
        end
    end

    // ==========================================================
    // Valid answers every read strobe, mapped or not
    always_ff @(posedge clk) begin
        if (rst) begin
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
        end
    end

    // Read data: summary, identity, system mode, magnetic events
    always_ff @(posedge clk) begin
        if (rst) begin
            regReadData <= `MSIRQ_BYTE_ZERO;
        end else begin
            if (!regRead) begin
                regReadData <= regReadData;
            end else if (regAddr == `MSIRQ_ADDR_SUMMARY) begin
                regReadData <= interruptSummary;
            end else if (regAddr == `MSIRQ_ADDR_IDENTITY) begin
                regReadData <= IDENT_CODE;
            end else if (regAddr == `MSIRQ_ADDR_SYSTEM_MODE) begin
                regReadData <= {6'h00, systemMode};
            end else if (regAddr == `MSIRQ_ADDR_MAG_EVENT) begin
                regReadData <= magEventFlags;
            end else begin
                regReadData <= `MSIRQ_BYTE_ZERO;
            end
        end
    end

endmodule

// ### msirq_source_sva.sv
// Checker for the interrupt source block ports
module msirq_source_sva
    import msirq_pkg::*;
#(
    parameter int         INACT_WIDTH = 8,
    parameter logic [7:0] IDENT_CODE  = 8'h00
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              regRead,
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regReadData,
    input wire logic              regReadValid,
    input wire logic              burstStart,
    input wire logic              burstActive,
    input wire logic [7:0]        burstAddr,
    input wire logic              hybridAutoInc,
    input wire msirq_sense_type   senseMode,
    input wire logic              event_active,
    input wire logic              transientIntEnable,
    input wire logic              orientChanged,
    input wire logic              orientIntEnable,
    input wire logic              tapEventActive,
    input wire logic              tapIntEnable,
    input wire logic              magnitudeEvent,
    input wire msirq_sysmode_type systemMode,
    input wire logic              sleepRateSelect,
    input wire logic [7:0]        interruptSummary
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Sequences and properties
    sequence sRead(logic [7:0] a);
        regRead && regAddr == a;
    endsequence
    // A flag may only drop after the read that owns it
    property pHold(int b, logic [7:0] a);
        $fell(interruptSummary[b]) |-> $past(regRead) && $past(regAddr) == a;
    endproperty
    // ==========================================================
    // Assertions
    a_ident_read: assert property (sRead(8'h0D) |=> regReadValid && regReadData == IDENT_CODE)
        else $error("identity read wrong");
    a_magn_clear: assert property (sRead(8'h0C) ##0 !magnitudeEvent |=> !interruptSummary[1])
        else $error("magnitude flag not cleared");
    a_trans_set: assert property (event_active && transientIntEnable |=> interruptSummary[5])
        else $error("transient flag not set");
    a_orient_set: assert property (orientChanged && orientIntEnable |=> interruptSummary[4])
        else $error("orientation flag not set");
    a_tap_set: assert property (tapEventActive && tapIntEnable |=> interruptSummary[3])
        else $error("tap flag not set");
    a_sleep_hold: assert property (pHold(7, 8'h0B)) else $error("sleep flag dropped");
    a_buf_hold: assert property (pHold(6, 8'h00)) else $error("buffer flag dropped");
    a_trans_hold: assert property (pHold(5, 8'h1E)) else $error("transient flag dropped");
    a_orient_hold: assert property (pHold(4, 8'h10)) else $error("orient flag dropped");
    a_tap_hold: assert property (pHold(3, 8'h22)) else $error("tap flag dropped");
    a_ffmt_hold: assert property (pHold(2, 8'h16)) else $error("ffmt flag dropped");
    a_sleep_rate: assert property (sleepRateSelect == (systemMode == MSIRQ_MODE_SLEEP))
        else $error("sleep rate mismatch");
    a_mode_flag: assert property (($past(systemMode) == MSIRQ_MODE_WAKE && systemMode == MSIRQ_MODE_SLEEP)
        || ($past(systemMode) == MSIRQ_MODE_SLEEP && systemMode == MSIRQ_MODE_WAKE) |-> interruptSummary[7])
        else $error("mode change without flag");
    a_burst_begin: assert property (burstStart && senseMode == MSIRQ_SENSE_HYBRID && hybridAutoInc
        |=> burstActive && burstAddr == 8'h01) else $error("burst start wrong");
endmodule

// ### msirq_host.sv
// Host model: byte reads through the register read port
module msirq_host (
    input  wire logic       clk,
    output logic            regRead,
    output logic      [7:0] regAddr,
    input  wire logic [7:0] regReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clk) #1;
        regRead = 1'b0;
        // Released address shows the inverse so no stale match
        regAddr = ~a;
        d = regReadData;
    endtask
endmodule

// ### tb_msirq_source.sv
// Self-checking testbench of the interrupt source block
module tb_msirq_source;
    import msirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] IDENT = 8'h3C; // Arbitrary value
    logic clk = 0, rst = 1, bStart = 0, bNext = 0, act = 0, aslp = 0, autoInc = 0;
    logic magEn = 0, wakeSel = 0, tick = 0, actv = 0, ovf = 0, wmrk = 0, smp = 0;
    logic vecm = 0, accNew = 0, magNew = 0, regRead, regReadValid, burstActive, rate;
    logic [3:0] ev = 0, en = 0;
    logic [7:0] lim = 8'h03, regAddr, regReadData, burstAddr, summ, d;
    logic [7:0] magEv = 8'hA5;
    msirq_sense_type sense = MSIRQ_SENSE_ACCEL;
    msirq_sysmode_type mode;
    int n_errors = 0, checked = 0, cycles = 0;
    msirq_source #(.INACT_WIDTH(8), .IDENT_CODE(IDENT)) i_msirq_source (
        .clk(clk), .rst(rst), .regRead(regRead), .regAddr(regAddr), .regReadData(regReadData),
        .regReadValid(regReadValid), .burstStart(bStart), .burstNext(bNext), .burstAddr(burstAddr),
        .burstActive(burstActive), .active(act), .autoSleepEnable(aslp), .hybridAutoInc(autoInc),
        .senseMode(sense), .inactivityLimit(lim), .transientIntEnable(en[0]), .orientIntEnable(en[1]),
        .tapIntEnable(en[2]), .ffmtIntEnable(en[3]), .magnitudeIntEnable(magEn), .wakeEventSelect(wakeSel),
        .outputRateTick(tick), .activityDetected(actv), .bufferOverflow(ovf), .bufferWatermark(wmrk),
        .bufferSampleIn(smp), .event_active(ev[0]), .orientChanged(ev[1]), .tapEventActive(ev[2]),
        .ffmtEventActive(ev[3]), .magnitudeEvent(vecm), .accelDataNew(accNew), .magDataNew(magNew),
        .magEventFlags(magEv), .systemMode(mode), .sleepRateSelect(rate), .interruptSummary(summ));
    msirq_host hostModel (.clk(clk), .regRead(regRead), .regAddr(regAddr), .regReadData(regReadData));
    initial forever #12.5 clk = ~clk;
    // ==========================================================
    // Shared tasks
    task automatic step();
        @(posedge clk) #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ident();
        hostModel.rd(8'h0D, d); chk("identity", IDENT, d);
        hostModel.rd(8'h5E, d); chk("mag events", 8'hA5, d);
        magEv = 8'h69; hostModel.rd(8'h5E, d); chk("mag events", 8'h69, d);
        hostModel.rd(8'h7F, d); chk("unmapped", 8'h00, d);
    endtask
    task automatic t_flags();
        int bitPos[4] = '{5, 4, 3, 2};
        logic [7:0] clr[4] = '{8'h1E, 8'h10, 8'h22, 8'h16};
        for (int k = 0; k < 4; k++) begin
            ev[k] = 1; step(); ev = 0; step();
            chkb("disabled", 1'b0, summ[bitPos[k]]);
            en[k] = 1; ev[k] = 1; step(); ev = 0; step();
            chkb("set", 1'b1, summ[bitPos[k]]);
            hostModel.rd(8'h0C, d); chkb("summary read", 1'b1, summ[bitPos[k]]);
            hostModel.rd(clr[k], d); chkb("cleared", 1'b0, summ[bitPos[k]]);
            en = 0;
        end
    endtask
    task automatic t_vecm();
        magEn = 1; vecm = 1; step(); vecm = 0;
        chkb("vecm set", 1'b1, summ[1]);
        hostModel.rd(8'h0C, d); chkb("vecm data", 1'b1, d[1]);
        chkb("vecm clear", 1'b0, summ[1]);
    endtask
    task automatic t_drdy();
        accNew = 1; step(); accNew = 0; chkb("drdy acc", 1'b1, summ[0]);
        hostModel.rd(8'h33, d); chkb("drdy kept", 1'b1, summ[0]);
        hostModel.rd(8'h01, d); chkb("drdy clr", 1'b0, summ[0]);
        sense = MSIRQ_SENSE_MAG; magNew = 1; step(); magNew = 0; chkb("drdy mag", 1'b1, summ[0]);
        hostModel.rd(8'h01, d); chkb("drdy kept", 1'b1, summ[0]);
        hostModel.rd(8'h38, d); chkb("drdy clr", 1'b0, summ[0]);
        sense = MSIRQ_SENSE_HYBRID; accNew = 1; step(); accNew = 0; chkb("drdy hyb", 1'b1, summ[0]);
        hostModel.rd(8'h01, d); chkb("drdy kept", 1'b1, summ[0]);
        hostModel.rd(8'h33, d); chkb("drdy clr", 1'b0, summ[0]);
    endtask
    task automatic t_buffer();
        wmrk = 1; smp = 1; step(); smp = 0; chkb("wmrk", 1'b1, summ[6]);
        hostModel.rd(8'h00, d); step(); chkb("buf clr", 1'b0, summ[6]);
        wmrk = 0; ovf = 1; smp = 1; step(); smp = 0; chkb("ovf", 1'b1, summ[6]);
        hostModel.rd(8'h00, d); chkb("buf clr", 1'b0, summ[6]);
        ovf = 0;
    endtask
    task automatic t_sleep();
        act = 1; step(); step();
        chk("wake", {6'h00, MSIRQ_MODE_WAKE}, {6'h00, mode});
        chkb("standby exit", 1'b0, summ[7]);
        hostModel.rd(8'h0B, d); chkb("aslp clr", 1'b0, summ[7]);
        aslp = 1;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) chk("still awake", {6'h00, MSIRQ_MODE_WAKE}, {6'h00, mode});
            tick = 1; step(); tick = 0; step();
        end
        chk("sleep", {6'h00, MSIRQ_MODE_SLEEP}, {6'h00, mode});
        chkb("low rate", 1'b1, rate);
        chkb("aslp set", 1'b1, summ[7]);
        hostModel.rd(8'h0B, d); actv = 1; step(); step();
        chk("rewake", {6'h00, MSIRQ_MODE_WAKE}, {6'h00, mode});
        chkb("high rate", 1'b0, rate);
        chkb("aslp set", 1'b1, summ[7]);
        aslp = 0;
    endtask
    task automatic t_burst();
        sense = MSIRQ_SENSE_HYBRID; autoInc = 1; bStart = 1; step(); bStart = 0;
        chkb("burst on", 1'b1, burstActive); chk("burst addr", 8'h01, burstAddr);
        repeat (11) begin
            bNext = 1; step(); bNext = 0; step();
        end
        chk("burst last", 8'h0C, burstAddr); chkb("burst on", 1'b1, burstActive);
        bNext = 1; step(); bNext = 0; chkb("burst off", 1'b0, burstActive);
    endtask
    // ==========================================================
    // Main sequence and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        t_ident(); t_flags(); t_vecm(); t_drdy(); t_buffer(); t_sleep(); t_burst();
        conclude();
    end
endmodule
bind msirq_source msirq_source_sva #(.INACT_WIDTH(INACT_WIDTH), .IDENT_CODE(IDENT_CODE)) i_msirq_source_sva (
    .clk(clk), .rst(rst), .regRead(regRead), .regAddr(regAddr), .regReadData(regReadData),
    .regReadValid(regReadValid), .burstStart(burstStart), .burstActive(burstActive), .burstAddr(burstAddr),
    .hybridAutoInc(hybridAutoInc), .senseMode(senseMode), .event_active(event_active),
    .transientIntEnable(transientIntEnable), .orientChanged(orientChanged), .orientIntEnable(orientIntEnable),
    .tapEventActive(tapEventActive), .tapIntEnable(tapIntEnable), .magnitudeEvent(magnitudeEvent),
    .systemMode(systemMode), .sleepRateSelect(sleepRateSelect), .interruptSummary(interruptSummary));
